// >>> hw/jdr_pkg.sv
// Package: constants and types of the JTAG debug register set
// Contract
// - Instruction register 16 bits, CPU read-only
// - Instruction register initialises to bypass
// - TRST low or Test-Logic-Reset reinitialises instruction
// - Instruction loads from TDI in any CPU mode
// - Four-bit codes decoded from bits 15..12
// - Eight-bit codes decoded from bits 15..8
// - Unused low instruction bits always read one
// - Data register 32 bits, two halves, CPU read/write
// - Data register untouched by TRST and CPU reset
// - Bypass register one bit, no CPU access
// - Bypass instruction puts bypass bit in path
// - Interrupt source 16 bits, CPU read/write
// - Interrupt instruction at Update-IR sets flag
// - Interrupt instruction scans 32 bits, upper zero
// - CPU writing zero clears flag, one keeps
// - Interrupt request asserted while flag is one
// - TRST or Test-Logic-Reset clears interrupt source
// - Interrupt source bits 15..1 read zero
// - TRST or five TMS ones reset TAP
// - All but bypass mapped in CPU space
package jdr_pkg;
    localparam int          IR_W         = 16;
    localparam int          DATA_W       = 32;
    localparam int          INT_W        = 16;
    localparam int          SCAN_W       = 32;
    localparam int          ADDR_W       = 5;
    localparam logic [4:0]  OFS_INSTR    = 5'h00;
    localparam logic [4:0]  OFS_DATA_HI  = 5'h08;
    localparam logic [4:0]  OFS_DATA_LO  = 5'h0A;
    localparam logic [4:0]  OFS_INT_SRC  = 5'h14;
    localparam logic [15:0] IR_INIT      = 16'hFFFF;
    localparam logic [31:0] IR_CAPTURE   = 32'h0FFFFFFD;
    localparam logic [15:0] INT_INIT     = 16'h0000;
    localparam int          IRQ_BIT      = 0;
    localparam int          TLR_TMS_ONES = 5;

    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
        TS_PAU_DR, TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR,
        TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
    } jdr_tap_t;

    typedef enum logic [2:0] {
        CMD_BYPASS, CMD_IRQ, CMD_RST_ASSERT, CMD_RST_NEGATE,
        CMD_EXTEST, CMD_SAMPLE, CMD_RESERVED
    } jdr_cmd_t;
endpackage

// >>> hw/jdr_tap_if.sv
// Interface: TAP controller state flags toward the register core
`timescale 1ns/1ns
interface jdr_tap_if;
    logic tck_rise;
    logic tms;
    logic trst_act;
    logic in_tlr;
    logic cap_ir;
    logic shift_ir;
    logic upd_ir;
    logic cap_dr;
    logic shift_dr;
    modport fsm  (input  tck_rise, tms, trst_act,
                  output in_tlr, cap_ir, shift_ir, upd_ir, cap_dr, shift_dr);
    modport core (output tck_rise, tms, trst_act,
                  input  in_tlr, cap_ir, shift_ir, upd_ir, cap_dr, shift_dr);
endinterface

// >>> hw/jdr_tap.sv
// Module: IEEE 1149.1 TAP controller state machine
`timescale 1ns/1ns
module jdr_tap
    import jdr_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_b,
    jdr_tap_if.fsm    tap
);
    jdr_tap_t   state_r;
    jdr_tap_t   state_nxt;
    logic [2:0] ones_r;

    // Only TRST or TMS can reset the TAP; chip reset leaves it alone
    always_ff @(posedge clock) begin
        if (tap.trst_act) begin
            state_r <= TS_RESET;
        end else if (tap.tck_rise) begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        unique case (state_r)
            TS_RESET:  state_nxt = tap.tms ? TS_RESET  : TS_IDLE;
            TS_IDLE:   state_nxt = tap.tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: state_nxt = tap.tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: state_nxt = tap.tms ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  state_nxt = tap.tms ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: state_nxt = tap.tms ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: state_nxt = tap.tms ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: state_nxt = tap.tms ? TS_UPD_DR : TS_SH_DR;
            TS_UPD_DR: state_nxt = tap.tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: state_nxt = tap.tms ? TS_RESET  : TS_CAP_IR;
            TS_CAP_IR: state_nxt = tap.tms ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  state_nxt = tap.tms ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: state_nxt = tap.tms ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: state_nxt = tap.tms ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: state_nxt = tap.tms ? TS_UPD_IR : TS_SH_IR;
            TS_UPD_IR: state_nxt = tap.tms ? TS_SEL_DR : TS_IDLE;
        endcase
    end

    assign tap.in_tlr   = (state_r == TS_RESET);
    assign tap.cap_ir   = (state_r == TS_CAP_IR);
    assign tap.shift_ir = (state_r == TS_SH_IR);
    assign tap.upd_ir   = (state_r == TS_UPD_IR);
    assign tap.cap_dr   = (state_r == TS_CAP_DR);
    assign tap.shift_dr = (state_r == TS_SH_DR);

    // Helper: run of TCK rises with TMS high
    always_ff @(posedge clock) begin
        if (tap.trst_act || (tap.tck_rise && !tap.tms)) begin
            ones_r <= 3'h0;
        end else if (tap.tck_rise && ones_r != 3'h7) begin
            ones_r <= ones_r + 3'h1;
        end
    end

    tms_reset_a : assert property (@(posedge clock) disable iff (!rst_b)
        (ones_r >= 3'(TLR_TMS_ONES)) |-> tap.in_tlr)
        else $error("TAP not in reset after five TMS ones");
endmodule // jdr_tap

// >>> hw/jdr_top.sv
// Module: JTAG debug register set with CPU register port
`timescale 1ns/1ns
module jdr_top
    import jdr_pkg::*;
#(
    parameter int INSTR_BITS = 4
) (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    input  wire logic              trst_b,
    output logic                   tdo,
    output logic                   tdo_oe,
    input  wire logic              cpu_req,
    input  wire logic              cpu_we,
    input  wire logic              cpu_wide,
    input  wire logic [ADDR_W-1:0] cpu_addr,
    input  wire logic [DATA_W-1:0] cpu_wdata,
    output logic                   cpu_ack,
    output logic                   cpu_err,
    output logic [DATA_W-1:0]      cpu_rdata,
    output logic                   host_irq,
    output logic                   debug_reset_req
);
    localparam logic [15:0] LOW_ONES = 16'hFFFF >> INSTR_BITS;

    jdr_tap_if tap ();

    logic              tck_s1_r;
    logic              tck_s2_r;
    logic              tck_s3_r;
    logic              tms_s1_r;
    logic              tms_s2_r;
    logic              tdi_s1_r;
    logic              tdi_s2_r;
    logic              trst_s1_r;
    logic              trst_s2_r;
    logic              tck_fall;
    logic              trst_act;
    logic [IR_W-1:0]   debug_instruction_r;
    logic [IR_W-1:0]   ir_upd_val;
    logic [SCAN_W-1:0] shift_r;
    logic [DATA_W-1:0] debug_data_word_r;
    logic              host_irq_flag_r;
    logic [INT_W-1:0]  debug_interrupt_source;
    logic              dbg_rst_r;
    logic              tdo_r;
    logic              tdo_oe_r;
    logic              cpu_ack_r;
    logic              cpu_err_r;
    logic [DATA_W-1:0] cpu_rdata_r;
    logic              irq_path;
    logic              irq_set;
    logic              irq_clr;
    logic              ir_update;
    logic              ir_init;
    logic              hit;
    logic              wr_ok;
    logic [DATA_W-1:0] rd_val;
    jdr_cmd_t          cur_cmd;
    jdr_cmd_t          new_cmd;

    // Pin synchronisers; TCK edges are found from the second stage
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tck_s1_r  <= 1'b0;
            tck_s2_r  <= 1'b0;
            tck_s3_r  <= 1'b0;
            tms_s1_r  <= 1'b1;
            tms_s2_r  <= 1'b1;
            tdi_s1_r  <= 1'b1;
            tdi_s2_r  <= 1'b1;
        end else begin
            tck_s1_r  <= tck;
            tck_s2_r  <= tck_s1_r;
            tck_s3_r  <= tck_s2_r;
            tms_s1_r  <= tms;
            tms_s2_r  <= tms_s1_r;
            tdi_s1_r  <= tdi;
            tdi_s2_r  <= tdi_s1_r;
        end
    end

    // TRST path ignores chip reset so the TAP can be reset under it
    always_ff @(posedge clock) begin
        trst_s1_r <= trst_b;
        trst_s2_r <= trst_s1_r;
    end

    assign tap.tck_rise = tck_s2_r && !tck_s3_r;
    assign tck_fall     = !tck_s2_r && tck_s3_r;
    assign tap.tms      = tms_s2_r;
    assign trst_act     = !trst_s2_r;
    assign tap.trst_act = trst_act;

    jdr_tap u_tap (
        .clock (clock),
        .rst_b (rst_b),
        .tap   (tap)
    );

    // Host must not load reserved codes; they fall back to bypass here
    function automatic jdr_cmd_t decode(input logic [IR_W-1:0] ir);
        jdr_cmd_t c;
        c = CMD_RESERVED;
        if (INSTR_BITS == 4) begin
            casez (ir[15:12])
                4'b0110: c = CMD_RST_NEGATE;
                4'b0111: c = CMD_RST_ASSERT;
                4'b101?: c = CMD_IRQ;
                4'b1111: c = CMD_BYPASS;
                default: c = CMD_RESERVED;
            endcase
        end else begin
            casez (ir[15:8])
                8'h00:        c = CMD_EXTEST;
                8'h04:        c = CMD_SAMPLE;
                8'b0110????: c = CMD_RST_NEGATE;
                8'b0111????: c = CMD_RST_ASSERT;
                8'b101?????: c = CMD_IRQ;
                8'hFF:        c = CMD_BYPASS;
                default:      c = CMD_RESERVED;
            endcase
        end
        return c;
    endfunction

    assign ir_upd_val = shift_r[SCAN_W-1 -: IR_W] | LOW_ONES;
    assign cur_cmd    = decode(debug_instruction_r);
    assign new_cmd    = decode(ir_upd_val);
    assign irq_path   = (cur_cmd == CMD_IRQ);
    assign ir_update  = tck_fall && tap.upd_ir;
    assign ir_init    = trst_act || tap.in_tlr;

    // Instruction register: only the TAP writes it
    always_ff @(posedge clock) begin
        if (ir_init) begin
            debug_instruction_r <= IR_INIT;
        end else if (ir_update) begin
            debug_instruction_r <= ir_upd_val;
        end
    end

    // One scan chain serves IR, bypass bit and interrupt source
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            shift_r <= '0;
        end else if (tap.tck_rise) begin
            if (tap.cap_ir) begin
                shift_r <= IR_CAPTURE;
            end else if (tap.shift_ir) begin
                shift_r <= {tdi_s2_r, shift_r[SCAN_W-1:1]};
            end else if (tap.cap_dr) begin
                if (irq_path) begin
                    shift_r <= {16'h0000, debug_interrupt_source};
                end else begin
                    shift_r <= '0;
                end
            end else if (tap.shift_dr) begin
                if (irq_path) begin
                    shift_r <= {tdi_s2_r, shift_r[SCAN_W-1:1]};
                end else begin
                    shift_r <= {31'h0, tdi_s2_r};
                end
            end
        end
    end

    // TDO changes on the falling TCK edge
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (tck_fall) begin
            tdo_r    <= shift_r[0];
            tdo_oe_r <= tap.shift_ir || tap.shift_dr;
        end
    end

    assign tdo    = tdo_r;
    assign tdo_oe = tdo_oe_r;

    // CPU register decode
    always_comb begin
        hit    = 1'b0;
        rd_val = '0;
        unique case (cpu_addr)
            OFS_INSTR: begin
                hit    = !cpu_wide;
                rd_val = {16'h0000, debug_instruction_r};
            end
            OFS_DATA_HI: begin
                hit    = 1'b1;
                rd_val = cpu_wide ? debug_data_word_r
                                  : {16'h0000, debug_data_word_r[31:16]};
            end
            OFS_DATA_LO: begin
                hit    = !cpu_wide;
                rd_val = {16'h0000, debug_data_word_r[15:0]};
            end
            OFS_INT_SRC: begin
                hit    = !cpu_wide;
                rd_val = {16'h0000, debug_interrupt_source};
            end
            default: begin
                hit    = 1'b0;
                rd_val = '0;
            end
        endcase
    end

    assign wr_ok = cpu_req && cpu_we && hit;

    // Data register has no reset at all
    always_ff @(posedge clock) begin
        if (wr_ok && cpu_addr == OFS_DATA_HI) begin
            if (cpu_wide) begin
                debug_data_word_r <= cpu_wdata;
            end else begin
                debug_data_word_r[31:16] <= cpu_wdata[15:0];
            end
        end else if (wr_ok && cpu_addr == OFS_DATA_LO) begin
            debug_data_word_r[15:0] <= cpu_wdata[15:0];
        end
    end

    assign irq_set = ir_update && (new_cmd == CMD_IRQ);
    assign irq_clr = wr_ok && cpu_addr == OFS_INT_SRC && !cpu_wdata[IRQ_BIT];

    // A set in the same cycle as a CPU clear wins
    always_ff @(posedge clock) begin
        if (ir_init) begin
            host_irq_flag_r <= INT_INIT[IRQ_BIT];
        end else if (irq_set) begin
            host_irq_flag_r <= 1'b1;
        end else if (irq_clr) begin
            host_irq_flag_r <= 1'b0;
        end
    end

    assign debug_interrupt_source = {15'h0000, host_irq_flag_r};
    assign host_irq = host_irq_flag_r;

    always_ff @(posedge clock) begin
        if (ir_init) begin
            dbg_rst_r <= 1'b0;
        end else if (ir_update && new_cmd == CMD_RST_ASSERT) begin
            dbg_rst_r <= 1'b1;
        end else if (ir_update && new_cmd == CMD_RST_NEGATE) begin
            dbg_rst_r <= 1'b0;
        end
    end

    assign debug_reset_req = dbg_rst_r;

    // Reads may race a TAP update; software rereads until stable
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cpu_ack_r   <= 1'b0;
            cpu_err_r   <= 1'b0;
            cpu_rdata_r <= '0;
        end else begin
            cpu_ack_r   <= cpu_req;
            cpu_err_r   <= cpu_req && !hit;
            cpu_rdata_r <= (cpu_req && !cpu_we && hit) ? rd_val : '0;
        end
    end

    assign cpu_ack   = cpu_ack_r;
    assign cpu_err   = cpu_err_r;
    assign cpu_rdata = cpu_rdata_r;

    ir_cpu_ro_a : assert property (@(posedge clock) disable iff (!rst_b)
        (cpu_req && cpu_we && cpu_addr == OFS_INSTR && !ir_update && !ir_init)
        |=> $stable(debug_instruction_r))
        else $error("CPU write altered instruction register");

    ir_init_a : assert property (@(posedge clock) disable iff (!rst_b)
        trst_act |=> (debug_instruction_r == IR_INIT) && (cur_cmd == CMD_BYPASS))
        else $error("Instruction not bypass after TRST");

    ir_load_a : assert property (@(posedge clock) disable iff (!rst_b)
        (ir_update && !ir_init) |=> debug_instruction_r == $past(ir_upd_val))
        else $error("Instruction not loaded at Update-IR");

    ir_low_ones_a : assert property (@(posedge clock) disable iff (!rst_b)
        trst_s2_r |-> ((debug_instruction_r & LOW_ONES) == LOW_ONES))
        else $error("Unused instruction bits not one");

    bypass_path_a : assert property (@(posedge clock) disable iff (!rst_b)
        (tap.tck_rise && tap.shift_dr && cur_cmd == CMD_BYPASS)
        |=> shift_r == {31'h0, $past(tdi_s2_r)})
        else $error("Bypass bit did not take TDI");

    irq_capture_a : assert property (@(posedge clock) disable iff (!rst_b)
        (tap.tck_rise && tap.cap_dr && irq_path)
        |=> shift_r == {16'h0000, $past(debug_interrupt_source)})
        else $error("Interrupt source capture wrong");

    irq_set_a : assert property (@(posedge clock) disable iff (!rst_b)
        (irq_set && !ir_init) |=> host_irq ##1 host_irq)
        else $error("Interrupt command did not raise request");

    irq_cpu_a : assert property (@(posedge clock) disable iff (!rst_b)
        (wr_ok && cpu_addr == OFS_INT_SRC && !irq_set && !ir_init)
        |=> host_irq_flag_r == ($past(host_irq_flag_r) && $past(cpu_wdata[0])))
        else $error("CPU write to interrupt flag wrong");

    irq_init_a : assert property (@(posedge clock) disable iff (!rst_b)
        tap.in_tlr |=> (debug_interrupt_source == INT_INIT) && !host_irq)
        else $error("Interrupt source not cleared in reset");

    data_keep_a : assert property (@(posedge clock) disable iff (!rst_b)
        (trst_act && !(cpu_req && cpu_we)) |=> $stable(debug_data_word_r))
        else $error("Data register changed by TRST");
endmodule // jdr_top

// >>> sim/jdr_host.sv
// JTAG host model driving the link pins of the debug register set
`timescale 1ns/1ns
module jdr_host (
    input  wire logic clock,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_b
);
    // TCK stands low between frames; TMS and TDI rest at pull-up level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_b = 1'b0;
    end

    // Half of a 160 ns TCK period, aligned just after a clock edge
    task automatic half();
        repeat (8) @(posedge clock);
        #1;
    endtask

    // One TCK period; TDO taken just before the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        half();
        q = tdo_oe ? tdo : 1'bx;
        tck = 1'b1;
        half();
        tck = 1'b0;
    endtask

    // Ends in Run-Test/Idle
    task automatic trst_pulse();
        logic q;
        trst_b = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        trst_b = 1'b1;
        step(1'b0, 1'b1, q);
    endtask

    task automatic tlr_reset();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask

    // Idle to Idle; only legal codes are ever handed in
    task automatic scan(input logic ir, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        step(1'b1, 1'b1, q);
        if (ir) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < 32; i++) step(i == 31, din[i], dout[i]);
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        tdi = 1'b1;
        // Update lands a few clocks after the next-to-last fall; let the last fall settle
        half();
    endtask
endmodule // jdr_host

// >>> sim/jtag_debug_register_set_bench.sv
// Self-checking bench of the JTAG debug register set
`timescale 1ns/1ns
module jtag_debug_register_set_bench;
    import jdr_pkg::*;
    logic              clock;
    logic              rst_b;
    logic              tck;
    logic              tms;
    logic              tdi;
    logic              trst_b;
    logic              tdo;
    logic              tdo_oe;
    logic              cpu_req;
    logic              cpu_we;
    logic              cpu_wide;
    logic [ADDR_W-1:0] cpu_addr;
    logic [DATA_W-1:0] cpu_wdata;
    logic              cpu_ack;
    logic              cpu_err;
    logic [DATA_W-1:0] cpu_rdata;
    logic              host_irq;
    logic              debug_reset_req;
    logic [31:0]       q;
    int                n_mismatch = 0;
    int                n_tests = 0;

    jdr_top #(.INSTR_BITS(4)) dut_u (.clock(clock), .rst_b(rst_b),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo(tdo),
        .tdo_oe(tdo_oe), .cpu_req(cpu_req), .cpu_we(cpu_we),
        .cpu_wide(cpu_wide), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_ack(cpu_ack), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata),
        .host_irq(host_irq), .debug_reset_req(debug_reset_req));
    jdr_host host_u (.clock(clock), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_b(trst_b));

    always #5 clock = ~clock;

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle strobe; answer is looked at the cycle after
    task automatic acc(input logic we, input logic wide, input logic [4:0] a,
                       input logic [31:0] wd, input logic eexp,
                       output logic [31:0] rd);
        cpu_req = 1'b1;
        cpu_we = we;
        cpu_wide = wide;
        cpu_addr = a;
        cpu_wdata = wd;
        @(posedge clock);
        #1;
        chk({30'h0, cpu_ack, cpu_err}, {30'h0, 1'b1, eexp});
        rd = cpu_rdata;
        cpu_req = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic rd(input logic wide, input logic [4:0] a,
                      input logic [31:0] exp);
        logic [31:0] r;
        acc(1'b0, wide, a, 32'h0, 1'b0, r);
        chk(r, exp);
    endtask

    task automatic wr(input logic wide, input logic [4:0] a,
                      input logic [31:0] d);
        logic [31:0] r;
        acc(1'b1, wide, a, d, 1'b0, r);
    endtask

    // Read twice, retry up to three times until two reads agree
    task automatic rd_instr(input logic [15:0] exp);
        logic [31:0] a;
        logic [31:0] b;
        acc(1'b0, 1'b0, OFS_INSTR, 32'h0, 1'b0, b);
        for (int i = 0; i < 4; i++) begin
            a = b;
            acc(1'b0, 1'b0, OFS_INSTR, 32'h0, 1'b0, b);
            if (a === b) break;
        end
        chk(b, {16'h0, exp});
    endtask

    task automatic ir(input logic [15:0] code);
        logic [31:0] c;
        host_u.scan(1'b1, {code, 16'hFFFF}, c);
        chk(c, IR_CAPTURE);
    endtask

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        cpu_req = 1'b0;
        cpu_we = 1'b0;
        cpu_wide = 1'b0;
        cpu_addr = 5'h00;
        cpu_wdata = 32'h0;
        repeat (6) @(posedge clock);
        #1;
        rst_b = 1'b1;
        host_u.trst_pulse();
        rd_instr(16'hFFFF);
        rd(1'b0, OFS_INT_SRC, 32'h0);
        wr(1'b0, OFS_INSTR, 32'h0);
        rd_instr(16'hFFFF);
        acc(1'b0, 1'b0, 5'h04, 32'h0, 1'b1, q);
        acc(1'b0, 1'b1, OFS_DATA_LO, 32'h0, 1'b1, q);
        $display("test reset values done");

        wr(1'b1, OFS_DATA_HI, 32'hDEADBEEF);
        rd(1'b1, OFS_DATA_HI, 32'hDEADBEEF);
        wr(1'b0, OFS_DATA_LO, 32'h1234);
        rd(1'b0, OFS_DATA_HI, 32'hDEAD);
        rd(1'b0, OFS_DATA_LO, 32'h1234);
        rst_b = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        rst_b = 1'b1;
        host_u.trst_pulse();
        rd(1'b1, OFS_DATA_HI, 32'hDEAD1234);
        $display("test data register done");

        // Both codes of the 101x interrupt pattern
        for (int c = 10; c < 12; c++) begin
            ir({c[3:0], 12'hFFF});
            rd_instr({c[3:0], 12'hFFF});
            chk({31'h0, host_irq}, 32'h1);
            rd(1'b0, OFS_INT_SRC, 32'h1);
            host_u.scan(1'b0, 32'h0, q);
            chk(q, 32'h1);
            wr(1'b0, OFS_INT_SRC, 32'hFFFF);
            rd(1'b0, OFS_INT_SRC, 32'h1);
            chk({31'h0, host_irq}, 32'h1);
            wr(1'b0, OFS_INT_SRC, 32'hFFFE);
            rd(1'b0, OFS_INT_SRC, 32'h0);
            chk({31'h0, host_irq}, 32'h0);
        end
        $display("test interrupt done");

        ir(16'h7FFF);
        chk({31'h0, debug_reset_req}, 32'h1);
        ir(16'h6FFF);
        chk({31'h0, debug_reset_req}, 32'h0);
        ir(16'hFFFF);
        host_u.scan(1'b0, 32'h8000A5C3, q);
        chk(q, {32'h8000A5C3 << 1});
        $display("test commands and bypass done");

        ir(16'hAFFF);
        host_u.tlr_reset();
        rd_instr(16'hFFFF);
        rd(1'b0, OFS_INT_SRC, 32'h0);
        chk({31'h0, host_irq}, 32'h0);
        ir(16'h7FFF);
        ir(16'hAFFF);
        host_u.trst_pulse();
        rd_instr(16'hFFFF);
        rd(1'b0, OFS_INT_SRC, 32'h0);
        chk({30'h0, debug_reset_req, host_irq}, 32'h0);
        $display("test link resets done");
        summarize();
    end

    // Whole run needs about 70 us of link traffic
    initial begin
        #600000;
        n_mismatch++;
        $display("watchdog expired");
        summarize();
    end
endmodule // jtag_debug_register_set_bench
